// ===== audio_codec_control_regs.v
// control and status register bank of the audio codec subsystem
// assumes a simple synchronous register port on i_core_clk; the
// overload status comes from the analog domain and is synchronised here
//
// Summary of operation
// - dac clock halve bit selects divide one or two
// - bit 10 enables jack detect interrupt
// - overcurrent irq when enabled, protected, overloaded
// - serial transmit driven only when enable set
// - wiring field: three, four, six wire
// - dac source 00 is music channel
// - dac input rate mclk/256 or mclk/128
// - dac output rate mclk/16 down to /2
// - eight-bit volume per channel, reset BE
// - headphone volume clamps at 40, reads raw
// - playback bit 0 mutes, 1 passes
// - output sum route mixes both channels
// - overload state read-only at bit 14
// - protect bit 0 enables overload protection
// - capture sum adds left and right samples
// - adc gain 0 to 45 dB, 3 dB steps
// - wind filter rate family select
// - wind filter cutoff three-bit code
// - highpass enables are active low
// - capture channels enabled by bits 4, 3
// - radio input gain code, reset 010
`timescale 1ns/10ps
`include "audio_codec_control_regs_defines.vh"

module audio_codec_control_regs (
  input  wire        i_core_clk,
  input  wire        i_rst,
  input  wire        i_wr_en,
  input  wire        i_rd_en,
  input  wire [3:0]  i_addr,
  input  wire [15:0] i_wdata,
  input  wire        i_overload_raw,
  input  wire        i_jack_event,
  output reg  [15:0] o_rdata,
  output reg         o_rd_valid,
  output reg         o_irq,
  output reg         o_dac_clk_halve,
  output reg         o_serial_out_en,
  output reg         o_serial_tx_oe_n,
  output reg  [1:0]  o_serial_wiring_sel,
  output reg         o_dac_from_music,
  output reg  [8:0]  o_dac_in_div,
  output reg  [4:0]  o_dac_out_div,
  output reg  [7:0]  o_right_digital_gain,
  output reg  [7:0]  o_left_digital_gain,
  output reg  [5:0]  o_hp_volume,
  output reg         o_playback_pass,
  output reg         o_output_sum_route,
  output reg         o_overload_protect_on,
  output reg         o_capture_sum_en,
  output reg  [3:0]  o_adc_gain,
  output reg  [1:0]  o_wind_rate_family,
  output reg  [2:0]  o_wind_cutoff_sel,
  output reg         o_highpass_for_wind,
  output reg         o_left_highpass_on,
  output reg         o_right_highpass_on,
  output reg         o_left_capture_en,
  output reg         o_right_capture_en,
  output reg  [2:0]  o_radio_input_gain
);

  // --------------------------------------------------------------------
  // register storage
  // --------------------------------------------------------------------
  localparam NREG = 16;

  reg  [15:0] regs_reg [0:NREG-1];
  reg  [15:0] rst_val  [0:NREG-1];
  reg  [15:0] msk_val  [0:NREG-1];
  reg         init_done_reg;
  reg         ovl_meta_reg;
  reg         ovl_sync_reg;
  reg  [15:0] rdata_next;
  integer     k;

  always @* begin
    for (k = 0; k < NREG; k = k + 1) begin
      rst_val[k] = 16'h0000;
      msk_val[k] = 16'h0000;
    end
    rst_val[`OFS_AUDIO_PORT_CONTROL]     = `RST_AUDIO_PORT_CONTROL;
    rst_val[`OFS_DAC_DIGITAL_CONTROL]    = `RST_DAC_DIGITAL_CONTROL;
    rst_val[`OFS_DAC_VOLUME_CONTROL]     = `RST_DAC_VOLUME_CONTROL;
    rst_val[`OFS_DAC_ANALOG_BIAS_0]      = `RST_DAC_ANALOG_BIAS_0;
    rst_val[`OFS_DAC_ANALOG_MUTE_VOLUME] = `RST_DAC_ANALOG_MUTE_VOLUME;
    rst_val[`OFS_DAC_ANALOG_OUTPUT_CFG]  = `RST_DAC_ANALOG_OUTPUT_CFG;
    rst_val[`OFS_DAC_ANALOG_ENABLE_STAT] = `RST_DAC_ANALOG_ENABLE_STAT;
    rst_val[`OFS_ADC_DIGITAL_CONTROL]    = `RST_ADC_DIGITAL_CONTROL;
    rst_val[`OFS_ADC_HIGHPASS_CONTROL]   = `RST_ADC_HIGHPASS_CONTROL;
    rst_val[`OFS_ADC_INPUT_CONTROL]      = `RST_ADC_INPUT_CONTROL;
    msk_val[`OFS_AUDIO_PORT_CONTROL]     = `MSK_AUDIO_PORT_CONTROL;
    msk_val[`OFS_DAC_DIGITAL_CONTROL]    = `MSK_DAC_DIGITAL_CONTROL;
    msk_val[`OFS_DAC_VOLUME_CONTROL]     = `MSK_DAC_VOLUME_CONTROL;
    msk_val[`OFS_DAC_ANALOG_BIAS_0]      = `MSK_DAC_ANALOG_BIAS_0;
    msk_val[`OFS_DAC_ANALOG_MUTE_VOLUME] = `MSK_DAC_ANALOG_MUTE_VOLUME;
    msk_val[`OFS_DAC_ANALOG_OUTPUT_CFG]  = `MSK_DAC_ANALOG_OUTPUT_CFG;
    msk_val[`OFS_DAC_ANALOG_ENABLE_STAT] = `MSK_DAC_ANALOG_ENABLE_STAT;
    msk_val[`OFS_ADC_DIGITAL_CONTROL]    = `MSK_ADC_DIGITAL_CONTROL;
    msk_val[`OFS_ADC_HIGHPASS_CONTROL]   = `MSK_ADC_HIGHPASS_CONTROL;
    msk_val[`OFS_ADC_INPUT_CONTROL]      = `MSK_ADC_INPUT_CONTROL;
  end

  // one generate loop covers every register slot
  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1) begin : g_reg
      always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
          regs_reg[g] <= 16'h0000;
        end else if (i_wr_en && (i_addr == g)) begin
          // reserved bits stay zero
          regs_reg[g] <= i_wdata & msk_val[g];
        end else if (regs_reg[g] == 16'h0000 && !init_done_reg) begin
          regs_reg[g] <= rst_val[g];
        end
      end
    end
  endgenerate

  // reset loads documented values one cycle after release
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      init_done_reg <= 1'b0;
    end else begin
      init_done_reg <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // overload status synchroniser
  // --------------------------------------------------------------------
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ovl_meta_reg <= 1'b0;
      ovl_sync_reg <= 1'b0;
    end else begin
      ovl_meta_reg <= i_overload_raw;
      ovl_sync_reg <= ovl_meta_reg;
    end
  end

  // --------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------
  wire [15:0] r_port = regs_reg[`OFS_AUDIO_PORT_CONTROL];
  wire [15:0] r_ddig = regs_reg[`OFS_DAC_DIGITAL_CONTROL];
  wire [15:0] r_dvol = regs_reg[`OFS_DAC_VOLUME_CONTROL];
  wire [15:0] r_amv  = regs_reg[`OFS_DAC_ANALOG_MUTE_VOLUME];
  wire [15:0] r_aout = regs_reg[`OFS_DAC_ANALOG_OUTPUT_CFG];
  wire [15:0] r_adig = regs_reg[`OFS_ADC_DIGITAL_CONTROL];
  wire [15:0] r_hpf  = regs_reg[`OFS_ADC_HIGHPASS_CONTROL];
  wire [15:0] r_ain  = regs_reg[`OFS_ADC_INPUT_CONTROL];

  always @* begin
    rdata_next = regs_reg[i_addr];
    if (i_addr == `OFS_DAC_ANALOG_ENABLE_STAT) begin
      // read-only overload state
      rdata_next[`POS_OVERLOAD_STATE] = ovl_sync_reg;
    end
  end

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata    <= 16'h0000;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en) begin
        o_rdata <= rdata_next;
      end
    end
  end

  // --------------------------------------------------------------------
  // decoded controls
  // --------------------------------------------------------------------
  wire [5:0] hp_vol_raw = r_amv[`POS_HP_VOLUME_LO +: 6];
  wire       prot_on    = ~r_aout[`POS_OVERLOAD_PROTECT_OFF];
  wire       oc_irq     = r_port[`POS_OVERCURRENT_IRQ_EN] & prot_on &
                          ovl_sync_reg;
  wire       jk_irq     = r_port[`POS_JACK_DETECT_IRQ_EN] & i_jack_event;
  wire [1:0] out_rate   = r_ddig[`POS_DAC_OUT_RATE_LO +: 2];

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq                 <= 1'b0;
      o_dac_clk_halve       <= 1'b0;
      o_serial_out_en       <= 1'b0;
      o_serial_tx_oe_n      <= 1'b1;
      o_serial_wiring_sel   <= 2'h0;
      o_dac_from_music      <= 1'b1;
      o_dac_in_div          <= 9'h100;
      o_dac_out_div         <= 5'h10;
      o_right_digital_gain  <= 8'hBE;
      o_left_digital_gain   <= 8'hBE;
      o_hp_volume           <= 6'h00;
      o_playback_pass       <= 1'b0;
      o_output_sum_route    <= 1'b0;
      o_overload_protect_on <= 1'b1;
      o_capture_sum_en      <= 1'b0;
      o_adc_gain            <= 4'h0;
      o_wind_rate_family    <= 2'h0;
      o_wind_cutoff_sel     <= 3'h0;
      o_highpass_for_wind   <= 1'b0;
      o_left_highpass_on    <= 1'b1;
      o_right_highpass_on   <= 1'b1;
      o_left_capture_en     <= 1'b0;
      o_right_capture_en    <= 1'b0;
      o_radio_input_gain    <= 3'h2;
    end else begin
      o_irq               <= oc_irq | jk_irq;
      o_dac_clk_halve     <= r_port[`POS_DAC_CLK_HALVE];
      o_serial_out_en     <= r_port[`POS_SERIAL_OUT_EN];
      o_serial_tx_oe_n    <= ~r_port[`POS_SERIAL_OUT_EN];
      o_serial_wiring_sel <= r_port[`POS_SERIAL_WIRING_LO +: 2];
      o_dac_from_music    <= (r_ddig[`POS_DAC_SOURCE_LO +: 2] ==
                              `DAC_SOURCE_MUSIC);
      o_dac_in_div        <= r_ddig[`POS_DAC_IN_RATE] ?
                             9'h080 : 9'h100;
      case (out_rate)
        2'h0:    o_dac_out_div <= 5'h10;
        2'h1:    o_dac_out_div <= 5'h08;
        2'h2:    o_dac_out_div <= 5'h04;
        default: o_dac_out_div <= 5'h02;
      endcase
      o_right_digital_gain <= r_dvol[15:8];
      o_left_digital_gain  <= r_dvol[7:0];
      o_hp_volume <= (hp_vol_raw > `HP_VOLUME_MAX) ?
                     `HP_VOLUME_MAX : hp_vol_raw;
      o_playback_pass      <= r_amv[`POS_PLAYBACK_SILENCE];
      o_output_sum_route   <= r_aout[`POS_OUTPUT_SUM_ROUTE];
      o_overload_protect_on <= prot_on;
      o_capture_sum_en     <= r_adig[`POS_CAPTURE_SUM_EN];
      o_adc_gain           <= r_adig[`POS_ADC_GAIN_LO +: 4];
      o_wind_rate_family   <= r_hpf[`POS_WIND_RATE_LO +: 2];
      o_wind_cutoff_sel    <= r_hpf[`POS_WIND_CUTOFF_LO +: 3];
      o_highpass_for_wind  <= r_hpf[`POS_HIGHPASS_PURPOSE];
      o_left_highpass_on   <= ~r_hpf[`POS_LEFT_HIGHPASS_OFF];
      o_right_highpass_on  <= ~r_hpf[`POS_RIGHT_HIGHPASS_OFF];
      o_left_capture_en    <= r_ain[`POS_LEFT_CAPTURE_EN];
      o_right_capture_en   <= r_ain[`POS_RIGHT_CAPTURE_EN];
      o_radio_input_gain   <= r_ain[`POS_RADIO_GAIN_LO +: 3];
    end
  end

endmodule // audio_codec_control_regs

// ===== audio_codec_control_regs_assertions.sv
// concurrent checks for the audio codec control register bank
// bound to the bank top module; sees its ports only
`timescale 1ns/10ps

module audio_codec_control_regs_assertions (
  input wire        i_core_clk,
  input wire        i_rst,
  input wire        i_wr_en,
  input wire [3:0]  i_addr,
  input wire [15:0] i_wdata,
  input wire        o_irq,
  input wire        o_dac_clk_halve,
  input wire        o_serial_tx_oe_n,
  input wire [8:0]  o_dac_in_div,
  input wire [4:0]  o_dac_out_div,
  input wire [7:0]  o_right_digital_gain,
  input wire [7:0]  o_left_digital_gain,
  input wire [5:0]  o_hp_volume,
  input wire        o_playback_pass,
  input wire        o_output_sum_route,
  input wire        o_overload_protect_on,
  input wire        o_left_highpass_on,
  input wire        o_right_highpass_on,
  input wire        o_left_capture_en,
  input wire        o_right_capture_en
);
  // ----------------------------------------------------------------
  // write to output relations, two cycles after the write edge
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  property p_halve;
    i_wr_en && i_addr == 4'h0 |-> ##2
      o_dac_clk_halve == $past(i_wdata[11], 2);
  endproperty
  a_halve: assert property (p_halve) else $error("clock halve wrong");
  property p_oe;
    i_wr_en && i_addr == 4'h0 |-> ##2
      o_serial_tx_oe_n == !$past(i_wdata[8], 2);
  endproperty
  a_oe: assert property (p_oe) else $error("serial enable wrong");
  property p_irq_off;
    i_wr_en && i_addr == 4'h0 && i_wdata[10:9] == 2'h0 |-> ##2 !o_irq [*3];
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq not masked");
  property p_rates;
    i_wr_en && i_addr == 4'h2 |-> ##2
      o_dac_in_div == ($past(i_wdata[8], 2) ? 9'h080 : 9'h100) &&
      o_dac_out_div == (5'h10 >> $past(i_wdata[5:4], 2));
  endproperty
  a_rates: assert property (p_rates) else $error("dac rate wrong");
  property p_gain;
    i_wr_en && i_addr == 4'h3 |-> ##2
      {o_right_digital_gain, o_left_digital_gain} == $past(i_wdata, 2);
  endproperty
  a_gain: assert property (p_gain) else $error("volume wrong");
  property p_hp;
    i_wr_en && i_addr == 4'h5 |-> ##2
      o_hp_volume == ($past(i_wdata[5:0], 2) > 6'h28 ? 6'h28 :
      $past(i_wdata[5:0], 2)) && o_playback_pass == $past(i_wdata[10], 2);
  endproperty
  a_hp: assert property (p_hp) else $error("headphone volume wrong");
  property p_mix;
    i_wr_en && i_addr == 4'h6 |-> ##2 o_output_sum_route ==
      $past(i_wdata[6], 2) && o_overload_protect_on == !$past(i_wdata[5], 2);
  endproperty
  a_mix: assert property (p_mix) else $error("mix or protect wrong");
  property p_hpf;
    i_wr_en && i_addr == 4'h9 |-> ##2 o_left_highpass_on ==
      !$past(i_wdata[1], 2) && o_right_highpass_on == !$past(i_wdata[0], 2);
  endproperty
  a_hpf: assert property (p_hpf) else $error("highpass enable wrong");
  property p_capture;
    i_wr_en && i_addr == 4'hA |-> ##2
      {o_left_capture_en, o_right_capture_en} == $past(i_wdata[4:3], 2);
  endproperty
  a_capture: assert property (p_capture) else $error("capture wrong");

  c_irq: cover property (o_irq);
  c_clamp: cover property (i_wr_en && i_addr == 4'h5 && i_wdata[5:0] > 6'h28);
  c_wind: cover property (!o_left_highpass_on && !o_right_highpass_on);
endmodule // audio_codec_control_regs_assertions

bind audio_codec_control_regs audio_codec_control_regs_assertions u_chk (.*);

// ===== audio_codec_control_regs_defines.vh
// register map constants for the audio codec control bank
// included by the register bank module; definitions only
`ifndef AUDIO_CODEC_CONTROL_REGS_DEFINES_VH
`define AUDIO_CODEC_CONTROL_REGS_DEFINES_VH

// ----------------------------------------------------------------------
// offsets
// ----------------------------------------------------------------------
`define OFS_AUDIO_PORT_CONTROL      4'h0
`define OFS_DAC_DIGITAL_CONTROL     4'h2
`define OFS_DAC_VOLUME_CONTROL      4'h3
`define OFS_DAC_ANALOG_BIAS_0       4'h4
`define OFS_DAC_ANALOG_MUTE_VOLUME  4'h5
`define OFS_DAC_ANALOG_OUTPUT_CFG   4'h6
`define OFS_DAC_ANALOG_ENABLE_STAT  4'h7
`define OFS_ADC_DIGITAL_CONTROL     4'h8
`define OFS_ADC_HIGHPASS_CONTROL    4'h9
`define OFS_ADC_INPUT_CONTROL       4'hA

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_AUDIO_PORT_CONTROL      16'h0000
`define RST_DAC_DIGITAL_CONTROL     16'h0000
`define RST_DAC_VOLUME_CONTROL      16'hBEBE
`define RST_DAC_ANALOG_BIAS_0       16'h5355
`define RST_DAC_ANALOG_MUTE_VOLUME  16'h0040
`define RST_DAC_ANALOG_OUTPUT_CFG   16'h0000
`define RST_DAC_ANALOG_ENABLE_STAT  16'h00B0
`define RST_ADC_DIGITAL_CONTROL     16'h0000
`define RST_ADC_HIGHPASS_CONTROL    16'h0000
`define RST_ADC_INPUT_CONTROL       16'h0800

// ----------------------------------------------------------------------
// writable bit masks (reserved bits read zero)
// ----------------------------------------------------------------------
`define MSK_AUDIO_PORT_CONTROL      16'h0F60
`define MSK_DAC_DIGITAL_CONTROL     16'h0FFF
`define MSK_DAC_VOLUME_CONTROL      16'hFFFF
`define MSK_DAC_ANALOG_BIAS_0       16'hF7F7
`define MSK_DAC_ANALOG_MUTE_VOLUME  16'hC7FF
`define MSK_DAC_ANALOG_OUTPUT_CFG   16'h8FFF
`define MSK_DAC_ANALOG_ENABLE_STAT  16'h27FF
`define MSK_ADC_DIGITAL_CONTROL     16'h1BC0
`define MSK_ADC_HIGHPASS_CONTROL    16'h00FF
`define MSK_ADC_INPUT_CONTROL       16'h7CFF

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define POS_DAC_CLK_HALVE           11
`define POS_JACK_DETECT_IRQ_EN      10
`define POS_OVERCURRENT_IRQ_EN      9
`define POS_SERIAL_OUT_EN           8
`define POS_SERIAL_WIRING_LO        5
`define POS_DAC_SOURCE_LO           10
`define POS_DAC_IN_RATE             8
`define POS_DAC_OUT_RATE_LO         4
`define POS_PLAYBACK_SILENCE        10
`define POS_HP_VOLUME_LO            0
`define POS_OUTPUT_SUM_ROUTE        6
`define POS_OVERLOAD_PROTECT_OFF    5
`define POS_OVERLOAD_STATE          14
`define POS_CAPTURE_SUM_EN          11
`define POS_ADC_GAIN_LO             6
`define POS_WIND_RATE_LO            6
`define POS_WIND_CUTOFF_LO          3
`define POS_HIGHPASS_PURPOSE        2
`define POS_LEFT_HIGHPASS_OFF       1
`define POS_RIGHT_HIGHPASS_OFF      0
`define POS_LEFT_CAPTURE_EN         4
`define POS_RIGHT_CAPTURE_EN        3
`define POS_RADIO_GAIN_LO           10

// ----------------------------------------------------------------------
// codes and limits
// ----------------------------------------------------------------------
`define HP_VOLUME_MAX               6'h28
`define WIRING_RESERVED             2'h3
`define WIND_RATE_RESERVED          2'h3
`define DAC_SOURCE_MUSIC            2'h0

`endif

// ===== audio_codec_control_regs_tb.sv
// self-checking bench for the audio codec control register bank
// drives the register port and status inputs directly
`timescale 1ns/10ps

module audio_codec_control_regs_tb;
  reg         i_core_clk = 1'b0;
  reg         i_rst = 1'b1;
  reg         i_wr_en = 1'b0;
  reg         i_rd_en = 1'b0;
  reg  [3:0]  i_addr = 4'h0;
  reg  [15:0] i_wdata = 16'h0000;
  reg         i_overload_raw = 1'b0;
  reg         i_jack_event = 1'b0;
  wire [15:0] o_rdata;
  wire        o_rd_valid, o_irq, o_dac_clk_halve, o_serial_out_en;
  wire        o_serial_tx_oe_n, o_dac_from_music, o_playback_pass;
  wire        o_output_sum_route, o_overload_protect_on, o_capture_sum_en;
  wire        o_highpass_for_wind, o_left_highpass_on, o_right_highpass_on;
  wire        o_left_capture_en, o_right_capture_en;
  wire [1:0]  o_serial_wiring_sel, o_wind_rate_family;
  wire [8:0]  o_dac_in_div;
  wire [4:0]  o_dac_out_div;
  wire [7:0]  o_right_digital_gain, o_left_digital_gain;
  wire [5:0]  o_hp_volume;
  wire [3:0]  o_adc_gain;
  wire [2:0]  o_wind_cutoff_sel, o_radio_input_gain;
  integer     num_errors = 0;
  integer     checks = 0;
  integer     k;
  reg  [31:0] m;

  audio_codec_control_regs dut (.*);

  always #2 i_core_clk = ~i_core_clk;

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
    end
  endtask

  task wr(input [3:0] a, input [15:0] d);
    begin
      @(posedge i_core_clk);
      i_wr_en <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_core_clk);
      i_wr_en <= 1'b0;
      repeat (2) @(posedge i_core_clk);
      #1;
    end
  endtask

  task rd(input [3:0] a, input [15:0] exp);
    begin
      @(posedge i_core_clk);
      i_rd_en <= 1'b1;
      i_addr <= a;
      @(posedge i_core_clk);
      i_rd_en <= 1'b0;
      #1;
      chk(o_rd_valid, 1'b1);
      chk(o_rdata, exp);
    end
  endtask

  // reset value and writable mask of each offset
  function [31:0] map(input [3:0] a);
    case (a)
      4'h0: map = {16'h0000, 16'h0F60};
      4'h2: map = {16'h0000, 16'h0FFF};
      4'h3: map = {16'hBEBE, 16'hFFFF};
      4'h4: map = {16'h5355, 16'hF7F7};
      4'h5: map = {16'h0040, 16'hC7FF};
      4'h6: map = {16'h0000, 16'h8FFF};
      4'h7: map = {16'h00B0, 16'h27FF};
      4'h8: map = {16'h0000, 16'h1BC0};
      4'h9: map = {16'h0000, 16'h00FF};
      4'hA: map = {16'h0800, 16'h7CFF};
      default: map = 32'h0000_0000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task reset_and_access;
    begin
      chk(o_left_digital_gain, 8'hBE);
      chk(o_radio_input_gain, 3'h2);
      chk(o_serial_tx_oe_n, 1'b1);
      chk(o_right_capture_en, 1'b0);
      for (k = 0; k < 16; k = k + 1) begin
        m = map(k[3:0]);
        rd(k[3:0], m[31:16]);
      end
      for (k = 0; k < 16; k = k + 1) begin
        m = map(k[3:0]);
        wr(k[3:0], 16'hFFFF);
        rd(k[3:0], m[15:0]);
        wr(k[3:0], 16'h0000);
        rd(k[3:0], 16'h0000);
      end
    end
  endtask

  task dac_fields;
    begin
      for (k = 0; k < 3; k = k + 1) begin
        wr(4'h0, {4'h0, 4'h9, 1'b0, k[1:0], 5'h00});
        chk(o_dac_clk_halve, 1'b1);
        chk(o_serial_wiring_sel, k[1:0]);
        chk(o_serial_tx_oe_n, 1'b0);
        chk(o_serial_out_en, 1'b1);
      end
      for (k = 0; k < 4; k = k + 1) begin
        wr(4'h2, {7'h00, k[0], 2'h0, k[1:0], 4'h0});
        chk(o_dac_in_div, k[0] ? 9'h080 : 9'h100);
        chk(o_dac_out_div, 5'h10 >> k[1:0]);
        chk(o_dac_from_music, 1'b1);
      end
      wr(4'h3, 16'hFF00);
      chk({o_right_digital_gain, o_left_digital_gain}, 16'hFF00);
      wr(4'h5, 16'h043F);
      chk(o_hp_volume, 6'h28);
      chk(o_playback_pass, 1'b1);
      rd(4'h5, 16'h043F);
      wr(4'h5, 16'h0027);
      chk(o_hp_volume, 6'h27);
      wr(4'h6, 16'h0040);
      chk(o_output_sum_route, 1'b1);
    end
  endtask

  task irq_paths;
    begin
      @(posedge i_core_clk);
      i_overload_raw <= 1'b1;
      wr(4'h6, 16'h0020);
      wr(4'h0, 16'h0200);
      chk(o_irq, 1'b0);
      wr(4'h6, 16'h0000);
      chk(o_irq, 1'b1);
      chk(o_overload_protect_on, 1'b1);
      rd(4'h7, 16'h4000);
      wr(4'h0, 16'h0400);
      chk(o_irq, 1'b0);
      @(posedge i_core_clk);
      i_overload_raw <= 1'b0;
      i_jack_event <= 1'b1;
      @(posedge i_core_clk);
      i_jack_event <= 1'b0;
      #1;
      chk(o_irq, 1'b1);
      @(posedge i_core_clk);
      #1;
      chk(o_irq, 1'b0);
    end
  endtask

  task adc_fields;
    begin
      wr(4'h8, 16'h0BC0);
      chk(o_capture_sum_en, 1'b1);
      chk(o_adc_gain, 4'hF);
      wr(4'h9, 16'h00BF);
      chk({o_wind_rate_family, o_wind_cutoff_sel}, 5'h17);
      chk(o_highpass_for_wind, 1'b1);
      chk(o_left_highpass_on, 1'b0);
      chk(o_right_highpass_on, 1'b0);
      wr(4'hA, 16'h1C18);
      chk({o_left_capture_en, o_right_capture_en}, 2'h3);
      chk(o_radio_input_gain, 3'h7);
    end
  endtask

  task wrap_up;
    begin
      $display("errors %0d, checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  initial begin
    repeat (20000) @(posedge i_core_clk);
    num_errors = num_errors + 1;
    wrap_up;
  end

  initial begin
    repeat (3) @(posedge i_core_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    #1;
    reset_and_access;
    dac_fields;
    irq_paths;
    adc_fields;
    wrap_up;
  end
endmodule // audio_codec_control_regs_tb
